// File: inc/lfm_pkg.sv
// Notes on behaviour
// - Report every fault by register, all but 100 C and supply-low by alarm pin.
// - Link loss forces loop current to alarm.
// - Controller reads fault register when alarm rises.
// - Valid access restarts watchdog only while alarm is inactive, except a status read after timeout.
// - Without auto readback, watchdog waits for status read.
// - Link fault after no valid access for period.
// - Codes 0-7 select 50..5000 ms periods.
// - Power-up watchdog enabled, one second timeout.
// - Direction strap picks upscale or downscale alarm.
// - Checked frame is 32 bits, check byte last.
// - Check byte is CRC8, polynomial x8+x2+x+1.
// - Bad check discards frame, flags, raises alarm.
// - Loop current deviation beyond tolerance is fault.
// - Low or high current flag, alarm either way.
// - Two die temperature flags, 100 and 140.
// - Only critical temperature flag raises alarm.
// - Supply-low flag sets below 0.6, clears above 0.7.
// - Supply-critical sets below 0.3, clears above 0.4.
// - Supply-critical flag raises the alarm pin.
// - Range straps select loop current range.
package lfm_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int unsigned MS_CYC = CLK_HZ / 1000;
   localparam int unsigned LINK_NS = 400;
   localparam int unsigned SCLK_HALF = LINK_NS / CLK_NS / 2;
   // Frame layout
   localparam int unsigned FRM_BITS = 24;
   localparam int unsigned CRC_BITS = 32;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_DAC = 8'h01;
   localparam logic [7:0] CMD_CTRL = 8'h02;
   localparam logic [7:0] CMD_RD_FAULT = 8'h03;
   // Control word fields
   localparam int unsigned CTRL_WD_LSB = 0;
   localparam int unsigned CTRL_WD_EN = 3;
   localparam int unsigned CTRL_AUTO_RB = 4;
   localparam logic [4:0] CTRL_RST = 5'h0B;
   // Fault register bits
   localparam int unsigned FLT_SPI = 0;
   localparam int unsigned FLT_CRC = 1;
   localparam int unsigned FLT_ILO = 2;
   localparam int unsigned FLT_IHI = 3;
   localparam int unsigned FLT_T100 = 4;
   localparam int unsigned FLT_T140 = 5;
   localparam int unsigned FLT_VLOW = 6;
   localparam int unsigned FLT_VCRIT = 7;
   localparam logic [15:0] FLT_ALARM_MASK = 16'h00AF;
   localparam logic [1:0] RANGE_4_20 = 2'h0;
   localparam logic [1:0] RANGE_3P8_21 = 2'h1;
   // Host register map
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_RDAT = 4'h8;
   localparam int unsigned CMD_CRC_BIT = 24;
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_REFUSED = 1;
   localparam int unsigned ST_ALARM = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      LFM_IDLE = 3'h0,
      LFM_HIGH = 3'h1,
      LFM_LOW = 3'h3,
      LFM_END = 3'h2,
      LFM_GAP = 3'h6
   } lfm_hst_t;

   function automatic int unsigned lfm_wd_ms(input logic [2:0] code);
      case (code)
         3'h0: return 50;
         3'h1: return 100;
         3'h2: return 500;
         3'h3: return 1000;
         3'h4: return 2000;
         3'h5: return 3000;
         3'h6: return 4000;
         default: return 5000;
      endcase
   endfunction : lfm_wd_ms

   function automatic logic [7:0] lfm_crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction : lfm_crc8
endpackage : lfm_pkg

// File: inc/lfm_link_if.sv
`timescale 1ns/1ps
interface lfm_link_if;
   logic sclk;
   logic sync_n;
   logic sdin;
   logic sdo_o;
   logic sdo_oe;
   logic sdo;
   logic alarm;
   // Undriven data line reads low
   assign sdo = sdo_oe ? sdo_o : 1'b0;
   modport dev (input sclk, input sync_n, input sdin, output sdo_o,
      output sdo_oe, output alarm);
   modport host (output sclk, output sync_n, output sdin, input sdo,
      input alarm);
endinterface : lfm_link_if

// File: verilog/lfm_dev.sv
`timescale 1ns/1ps
module lfm_dev #(
   parameter int unsigned MS_CYC = lfm_pkg::MS_CYC
) (
   input logic aclk,
   input logic aresetn,
   lfm_link_if.dev lnk,
   input logic alarm_dir,
   input logic [1:0] range_sel,
   input logic iloop_lo_cmp,
   input logic iloop_hi_cmp,
   input logic temp100_cmp,
   input logic temp140_cmp,
   input logic vloop_lt_0p6,
   input logic vloop_gt_0p7,
   input logic vloop_lt_0p3,
   input logic vloop_gt_0p4,
   output logic [15:0] dac_code,
   output logic [15:0] fault_reg,
   output logic alarm_force,
   output logic alarm_upscale,
   output logic [1:0] range_code
);
   logic [13:0] s1_q;
   logic [13:0] s2_q;
   logic sclk_s, sync_s, sdin_s, dir_s;
   logic [1:0] rng_s;
   logic ilo_s, ihi_s, t100_s, t140_s, lt06_s, gt07_s, lt03_s, gt04_s;
   logic sclk_d1_q, sync_d1_q;
   logic sclk_fall, sclk_rise, sync_fall, sync_rise;
   logic [31:0] sh_q;
   logic [5:0] cnt_q;
   logic [31:0] tx_q;
   logic rb_arm_q;
   logic [23:0] word;
   logic frm_ok, crc_bad;
   logic [7:0] cmd;
   logic [4:0] ctrl_q;
   logic st_rd;
   logic [31:0] wd_cnt_q;
   logic [31:0] wd_tmo;
   logic wd_halt_q;
   logic wd_to;
   logic spi_q, crc_q, ilo_q, ihi_q, t100_q, t140_q, vlow_q, vcrit_q;
   logic [15:0] flt;

   // Pins and comparators cross into aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 14'h0000;
         s2_q <= 14'h0000;
      end else begin
         s1_q <= {lnk.sclk, lnk.sync_n, lnk.sdin, alarm_dir, range_sel,
            iloop_lo_cmp, iloop_hi_cmp, temp100_cmp, temp140_cmp,
            vloop_lt_0p6, vloop_gt_0p7, vloop_lt_0p3, vloop_gt_0p4};
         s2_q <= s1_q;
      end
   end

   assign {sclk_s, sync_s, sdin_s, dir_s, rng_s, ilo_s, ihi_s, t100_s,
      t140_s, lt06_s, gt07_s, lt03_s, gt04_s} = s2_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_d1_q <= 1'b1;
         sync_d1_q <= 1'b1;
      end else begin
         sclk_d1_q <= sclk_s;
         sync_d1_q <= sync_s;
      end
   end

   assign sclk_fall = sclk_d1_q & ~sclk_s & ~sync_s;
   assign sclk_rise = ~sclk_d1_q & sclk_s & ~sync_s;
   assign sync_fall = sync_d1_q & ~sync_s;
   assign sync_rise = ~sync_d1_q & sync_s;

   // Count saturates so long frames are discarded
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sh_q <= 32'h0000_0000;
         cnt_q <= 6'h00;
      end else if (sync_fall) begin
         cnt_q <= 6'h00;
      end else if (sclk_fall) begin
         sh_q <= {sh_q[30:0], sdin_s};
         if (cnt_q != 6'h3F) begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end

   // Frame check at the rising frame select
   always_comb begin
      word = 24'h000000;
      frm_ok = 1'b0;
      crc_bad = 1'b0;
      if (sync_rise && cnt_q == 6'(lfm_pkg::FRM_BITS)) begin
         word = sh_q[23:0];
         frm_ok = 1'b1;
      end else if (sync_rise && cnt_q == 6'(lfm_pkg::CRC_BITS)) begin
         word = sh_q[31:8];
         if (lfm_pkg::lfm_crc8(sh_q[31:8]) == sh_q[7:0]) begin
            frm_ok = 1'b1;
         end else begin
            crc_bad = 1'b1;
         end
      end
   end

   assign cmd = word[23:16];
   assign st_rd = frm_ok &&
      (cmd == lfm_pkg::CMD_RD_FAULT || ctrl_q[lfm_pkg::CTRL_AUTO_RB]);

   // A discarded frame changes nothing here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= lfm_pkg::CTRL_RST;
         dac_code <= 16'h0000;
      end else if (frm_ok && cmd == lfm_pkg::CMD_CTRL) begin
         ctrl_q <= word[4:0];
      end else if (frm_ok && cmd == lfm_pkg::CMD_DAC) begin
         dac_code <= word[15:0];
      end
   end

   // Readback goes out in the next frame
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rb_arm_q <= 1'b0;
         tx_q <= 32'h0000_0000;
         lnk.sdo_o <= 1'b0;
         lnk.sdo_oe <= 1'b0;
      end else begin
         lnk.sdo_oe <= ~sync_s;
         if (sync_rise) begin
            rb_arm_q <= st_rd;
         end
         if (sync_fall) begin
            lnk.sdo_o <= rb_arm_q & flt[15];
            tx_q <= rb_arm_q ? {flt[14:0], 17'h00000} : 32'h0000_0000;
         end else if (sclk_rise) begin
            lnk.sdo_o <= tx_q[31];
            tx_q <= {tx_q[30:0], 1'b0};
         end
      end
   end

   assign wd_tmo = lfm_pkg::lfm_wd_ms(ctrl_q[lfm_pkg::CTRL_WD_LSB +: 3])
      * MS_CYC;
   assign wd_to = ctrl_q[lfm_pkg::CTRL_WD_EN] && !wd_halt_q &&
      wd_cnt_q >= wd_tmo - 32'd1;

   // Watchdog on aclk cycles since the last valid access
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wd_cnt_q <= 32'h0000_0000;
      end else if (!ctrl_q[lfm_pkg::CTRL_WD_EN] || wd_to) begin
         wd_cnt_q <= 32'h0000_0000;
      end else if (wd_halt_q) begin
         if (st_rd) begin
            wd_cnt_q <= 32'h0000_0000;
         end
      end else if (frm_ok && !lnk.alarm) begin
         wd_cnt_q <= 32'h0000_0000;
      end else begin
         wd_cnt_q <= wd_cnt_q + 32'd1;
      end
   end

   // Halt only matters when no readback happens on its own
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wd_halt_q <= 1'b0;
      end else if (wd_to && !ctrl_q[lfm_pkg::CTRL_AUTO_RB]) begin
         wd_halt_q <= 1'b1;
      end else if (st_rd || !ctrl_q[lfm_pkg::CTRL_WD_EN]) begin
         wd_halt_q <= 1'b0;
      end
   end

   // Sticky flags: a new event beats the clearing read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spi_q <= 1'b0;
         crc_q <= 1'b0;
      end else begin
         if (wd_to) begin
            spi_q <= 1'b1;
         end else if (st_rd) begin
            spi_q <= 1'b0;
         end
         if (crc_bad) begin
            crc_q <= 1'b1;
         end else if (st_rd) begin
            crc_q <= 1'b0;
         end
      end
   end

   // Level flags follow the synchronised comparators
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ilo_q <= 1'b0;
         ihi_q <= 1'b0;
         t100_q <= 1'b0;
         t140_q <= 1'b0;
      end else begin
         ilo_q <= ilo_s;
         ihi_q <= ihi_s;
         t100_q <= t100_s;
         t140_q <= t140_s;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vlow_q <= 1'b0;
         vcrit_q <= 1'b0;
      end else begin
         if (lt06_s) begin
            vlow_q <= 1'b1;
         end else if (gt07_s) begin
            vlow_q <= 1'b0;
         end
         if (lt03_s) begin
            vcrit_q <= 1'b1;
         end else if (gt04_s) begin
            vcrit_q <= 1'b0;
         end
      end
   end

   assign flt = {8'h00, vcrit_q, vlow_q, t140_q, t100_q, ihi_q, ilo_q,
      crc_q, spi_q};

   // The 100 C and supply-low flags are left out by the mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lnk.alarm <= 1'b0;
         fault_reg <= 16'h0000;
      end else begin
         lnk.alarm <= |(flt & lfm_pkg::FLT_ALARM_MASK);
         fault_reg <= flt;
      end
   end

   // Straps come from the synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_force <= 1'b0;
         alarm_upscale <= 1'b0;
         range_code <= lfm_pkg::RANGE_4_20;
      end else begin
         alarm_force <= spi_q;
         alarm_upscale <= dir_s;
         range_code <= rng_s;
      end
   end
endmodule : lfm_dev

// File: verilog/lfm_host.sv
`timescale 1ns/1ps
module lfm_host (
   input logic aclk,
   input logic aresetn,
   lfm_link_if.host lnk,
   input logic [3:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [3:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready
);
   logic aw_got_q, w_got_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic do_wr, start, rd_stat;
   logic refused_q;
   logic [1:0] s1_q, s2_q;
   lfm_pkg::lfm_hst_t st_q;
   logic [2:0] div_q;
   logic [31:0] tx_q, rx_q;
   logic [5:0] nb_q, bit_q;
   logic [15:0] rdat_q;
   logic half;

   assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
   assign start = do_wr && awaddr_q == lfm_pkg::REG_CMD &&
      st_q == lfm_pkg::LFM_IDLE;
   assign rd_stat = s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == lfm_pkg::REG_STAT;

   // Address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0000_0000;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lfm_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q == lfm_pkg::REG_CMD) ?
               lfm_pkg::RESP_OKAY : lfm_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // A command written while busy is dropped and remembered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refused_q <= 1'b0;
      end else if (do_wr && awaddr_q == lfm_pkg::REG_CMD && !start) begin
         refused_q <= 1'b1;
      end else if (rd_stat) begin
         refused_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= lfm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= lfm_pkg::RESP_OKAY;
         if (s_axi_araddr == lfm_pkg::REG_STAT) begin
            s_axi_rdata <= {29'h0, s2_q[1], refused_q,
               st_q != lfm_pkg::LFM_IDLE};
         end else if (s_axi_araddr == lfm_pkg::REG_RDAT) begin
            s_axi_rdata <= {16'h0000, rdat_q};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= lfm_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
      end else begin
         s1_q <= {lnk.alarm, lnk.sdo};
         s2_q <= s1_q;
      end
   end

   assign half = div_q == 3'(lfm_pkg::SCLK_HALF - 1);

   // Serial clock by divider; the far end samples on its falling edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= lfm_pkg::LFM_IDLE;
         div_q <= 3'h0;
         tx_q <= 32'h0000_0000;
         rx_q <= 32'h0000_0000;
         nb_q <= 6'h00;
         bit_q <= 6'h00;
         rdat_q <= 16'h0000;
         lnk.sclk <= 1'b1;
         lnk.sync_n <= 1'b1;
         lnk.sdin <= 1'b0;
      end else begin
         div_q <= (half || st_q == lfm_pkg::LFM_IDLE) ? 3'h0 : div_q + 3'h1;
         case (st_q)
            lfm_pkg::LFM_IDLE: begin
               if (start) begin
                  tx_q <= {wdata_q[23:0], lfm_pkg::lfm_crc8(wdata_q[23:0])};
                  nb_q <= wdata_q[lfm_pkg::CMD_CRC_BIT] ?
                     6'(lfm_pkg::CRC_BITS) : 6'(lfm_pkg::FRM_BITS);
                  bit_q <= 6'h00;
                  lnk.sync_n <= 1'b0;
                  lnk.sdin <= wdata_q[23];
                  st_q <= lfm_pkg::LFM_HIGH;
               end
            end
            lfm_pkg::LFM_HIGH: begin
               if (half) begin
                  lnk.sclk <= 1'b0;
                  st_q <= lfm_pkg::LFM_LOW;
               end
            end
            lfm_pkg::LFM_LOW: begin
               if (half) begin
                  rx_q <= {rx_q[30:0], s2_q[0]};
                  bit_q <= bit_q + 6'h01;
                  lnk.sclk <= 1'b1;
                  tx_q <= {tx_q[30:0], 1'b0};
                  lnk.sdin <= tx_q[30];
                  st_q <= (bit_q == nb_q - 6'h01) ?
                     lfm_pkg::LFM_END : lfm_pkg::LFM_HIGH;
               end
            end
            lfm_pkg::LFM_END: begin
               if (half) begin
                  lnk.sync_n <= 1'b1;
                  rdat_q <= (nb_q == 6'(lfm_pkg::CRC_BITS)) ?
                     rx_q[31:16] : rx_q[23:8];
                  st_q <= lfm_pkg::LFM_GAP;
               end
            end
            default: begin
               if (half) begin
                  st_q <= lfm_pkg::LFM_IDLE;
               end
            end
         endcase
      end
   end
endmodule : lfm_host

// File: sim/lfm_props.sv
`timescale 1ns/1ps
module lfm_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic alarm,
   input wire logic [15:0] fault_reg,
   input wire logic alarm_force
);
   logic [5:0] fall_cnt_q;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Falling sclk edges in this frame
   always_ff @(posedge aclk) begin
      if (!aresetn || $fell(sync_n)) begin
         fall_cnt_q <= 6'h00;
      end else if (!sync_n && $fell(sclk)) begin
         fall_cnt_q <= fall_cnt_q + 6'h01;
      end
   end

   sequence s_frame_end;
      $rose(sync_n);
   endsequence
   sequence s_alarm_on;
      alarm;
   endsequence

   a_frame_bits: assert property (
      s_frame_end |-> fall_cnt_q == 6'h18 || fall_cnt_q == 6'h20)
      else $error("frame not 24 or 32 bits");
   a_sclk_idle: assert property (
      sync_n && $past(sync_n) |-> sclk)
      else $error("sclk low outside frame");
   a_alarm_or_flags: assert property (
      alarm == |(fault_reg & lfm_pkg::FLT_ALARM_MASK))
      else $error("alarm differs from flags");
   a_force_follows: assert property (
      alarm_force == fault_reg[lfm_pkg::FLT_SPI])
      else $error("alarm current not forced");
   a_t100_quiet: assert property (
      fault_reg == 16'h0010 |-> !alarm)
      else $error("100 C flag raised alarm");
   a_t140_alarm: assert property (
      $rose(fault_reg[lfm_pkg::FLT_T140]) |-> s_alarm_on)
      else $error("140 C flag without alarm");
   a_vcrit_alarm: assert property (
      fault_reg[lfm_pkg::FLT_VCRIT] |-> s_alarm_on)
      else $error("supply flag without alarm");
   a_cur_alarm: assert property (
      fault_reg[lfm_pkg::FLT_ILO] || fault_reg[lfm_pkg::FLT_IHI]
      |-> s_alarm_on)
      else $error("current fault without alarm");
endmodule : lfm_props

// File: sim/lfm_tb_top.sv
`timescale 1ns/1ps
module lfm_tb_top;
   localparam int MS2 = 2;
   logic aclk, aresetn, alarm_dir;
   logic iloop_lo_cmp, iloop_hi_cmp, temp100_cmp, temp140_cmp;
   logic vloop_lt_0p6, vloop_gt_0p7, vloop_lt_0p3, vloop_gt_0p4;
   logic [1:0] rng1, rng2, rc1, rc2;
   logic [15:0] dac1, dac2, flt1, flt2;
   logic frc1, frc2, up1, up2;
   logic [3:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int per_ms[8] = '{50, 100, 500, 1000, 2000, 3000, 4000, 5000};

   lfm_link_if l1();
   lfm_link_if l2();
   lfm_dev #(.MS_CYC(20)) lfm_dev_inst (.aclk, .aresetn, .lnk(l1),
      .alarm_dir, .range_sel(rng1), .iloop_lo_cmp, .iloop_hi_cmp,
      .temp100_cmp, .temp140_cmp, .vloop_lt_0p6, .vloop_gt_0p7,
      .vloop_lt_0p3, .vloop_gt_0p4, .dac_code(dac1), .fault_reg(flt1),
      .alarm_force(frc1), .alarm_upscale(up1), .range_code(rc1));
   // Bench-driven link, so bad frames can be injected
   lfm_dev #(.MS_CYC(MS2)) lfm_dev_inst2 (.aclk, .aresetn, .lnk(l2),
      .alarm_dir, .range_sel(rng2), .iloop_lo_cmp, .iloop_hi_cmp,
      .temp100_cmp, .temp140_cmp, .vloop_lt_0p6, .vloop_gt_0p7,
      .vloop_lt_0p3, .vloop_gt_0p4, .dac_code(dac2), .fault_reg(flt2),
      .alarm_force(frc2), .alarm_upscale(up2), .range_code(rc2));
   lfm_host lfm_host_inst (.aclk, .aresetn, .lnk(l1), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   lfm_props lfm_props_inst (.aclk, .aresetn, .sclk(l1.sclk),
      .sync_n(l1.sync_n), .alarm(l1.alarm), .fault_reg(flt1),
      .alarm_force(frc1));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) if (aresetn) cyc <= cyc + 1;

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
         input logic [1:0] er);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (pa && s_axi_awready) begin
            pa = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (pw && s_axi_wready) begin
            pw = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
         input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   task automatic wait_idle();
      logic [31:0] s;
      do axi_rd(lfm_pkg::REG_STAT, s, lfm_pkg::RESP_OKAY);
      while (s[lfm_pkg::ST_BUSY] !== 1'b0);
   endtask : wait_idle

   task automatic hframe(input logic [7:0] cmd, input logic [15:0] d);
      axi_wr(lfm_pkg::REG_CMD, {8'h00, cmd, d}, lfm_pkg::RESP_OKAY);
      wait_idle();
   endtask : hframe

   // Bit driver for the second link
   task automatic bb_frame(input logic [31:0] w, input int n);
      @(posedge aclk) l2.sync_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         l2.sdin <= w[i];
         l2.sclk <= 1'b1;
         repeat (4) @(posedge aclk);
         l2.sclk <= 1'b0;
         repeat (4) @(posedge aclk);
      end
      l2.sclk <= 1'b1;
      repeat (4) @(posedge aclk);
      l2.sync_n <= 1'b1;
      l2.sdin <= ~w[0];
      repeat (6) @(posedge aclk);
   endtask : bb_frame

   function automatic int crc_m(input int d);
      int c = 0;
      for (int i = 23; i >= 0; i--) begin
         c = ((c << 1) ^ ((((c >> 7) ^ (d >> i)) & 1) ? 7 : 0)) & 255;
      end
      return c;
   endfunction : crc_m

   initial begin
      repeat (95000) @(posedge aclk);
      num_errors++;
      $display("BAD t=%0t timeout", $time);
      print_verdict();
   end

   initial begin
      logic [31:0] s;
      int w, c, iz, tz, vz, el, ec;
      void'($urandom(53));
      aresetn = 1'b0;
      alarm_dir = $urandom_range(1, 0);
      {rng1, rng2} = {lfm_pkg::RANGE_4_20, lfm_pkg::RANGE_3P8_21};
      {iloop_lo_cmp, iloop_hi_cmp, temp100_cmp, temp140_cmp} = 4'h0;
      {vloop_lt_0p6, vloop_lt_0p3, vloop_gt_0p4, vloop_gt_0p7} = 4'h3;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr} = 6'h00;
      {s_axi_araddr, s_axi_wdata} = 36'h0;
      {l2.sclk, l2.sync_n, l2.sdin} = 3'h6;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk({flt1, flt2}, 32'h0);
      chk({up1, up2}, {alarm_dir, alarm_dir});
      chk({rc1, rc2}, {rng1, rng2});
      axi_rd(lfm_pkg::REG_STAT, s, lfm_pkg::RESP_OKAY);
      chk(s, 32'h0);
      $display("test reset done");
      while (cyc < 19900) @(posedge aclk);
      chk(flt1[0], 1'b0);
      while (cyc < 20100) @(posedge aclk);
      chk({flt1[0], l1.alarm, frc1}, 3'h7);
      hframe(lfm_pkg::CMD_RD_FAULT, 16'h0000);
      chk(flt1, 16'h0000);
      $display("test watchdog done");
      el = 0;
      ec = 0;
      for (int k = 0; k < 12; k++) begin
         iz = (k == 11) ? 0 : $urandom_range(2, 0);
         tz = (k == 11) ? 0 : $urandom_range(2, 0);
         vz = (k == 11) ? 4 : $urandom_range(4, 0);
         @(posedge aclk);
         iloop_lo_cmp <= (iz == 1);
         iloop_hi_cmp <= (iz == 2);
         temp100_cmp <= (tz != 0);
         temp140_cmp <= (tz == 2);
         vloop_lt_0p3 <= (vz == 0);
         vloop_lt_0p6 <= (vz <= 2);
         vloop_gt_0p4 <= (vz >= 2);
         vloop_gt_0p7 <= (vz == 4);
         // Between thresholds a supply flag holds
         el = (vz <= 2) ? 1 : (vz == 4) ? 0 : el;
         ec = (vz == 0) ? 1 : (vz >= 2) ? 0 : ec;
         w = ec * 128 + el * 64 + (tz == 2) * 32 + (tz != 0) * 16;
         w = w + (iz == 2) * 8 + (iz == 1) * 4;
         repeat (6) @(posedge aclk);
         chk(flt1, w);
         chk(l1.alarm, (w & 32'hAC) != 0);
         axi_rd(lfm_pkg::REG_STAT, s, lfm_pkg::RESP_OKAY);
         chk(s[lfm_pkg::ST_ALARM], (w & 32'hAC) != 0);
      end
      $display("test comparators done");
      @(posedge aclk) temp100_cmp <= 1'b1;
      repeat (6) @(posedge aclk);
      hframe(lfm_pkg::CMD_RD_FAULT, 16'h0000);
      hframe(lfm_pkg::CMD_NOP, 16'h0000);
      axi_rd(lfm_pkg::REG_RDAT, s, lfm_pkg::RESP_OKAY);
      chk(s[15:0], 16'h0010);
      @(posedge aclk) temp100_cmp <= 1'b0;
      $display("test readback done");
      for (int k = 0; k < 4; k++) begin
         w = $urandom;
         axi_wr(lfm_pkg::REG_CMD, {7'h00, k[0], 8'h01, w[15:0]}, 2'h0);
         wait_idle();
         chk({flt1[1], dac1}, {1'b0, w[15:0]});
      end
      w = $urandom;
      axi_wr(lfm_pkg::REG_CMD, {16'h0001, w[15:0]}, lfm_pkg::RESP_OKAY);
      axi_wr(lfm_pkg::REG_CMD, {16'h0001, ~w[15:0]}, lfm_pkg::RESP_OKAY);
      axi_rd(lfm_pkg::REG_STAT, s, lfm_pkg::RESP_OKAY);
      chk(s[lfm_pkg::ST_REFUSED], 1'b1);
      wait_idle();
      axi_rd(lfm_pkg::REG_STAT, s, lfm_pkg::RESP_OKAY);
      chk({s[lfm_pkg::ST_REFUSED], dac1}, {1'b0, w[15:0]});
      axi_wr(4'hC, $urandom, lfm_pkg::RESP_SLVERR);
      axi_rd(4'hC, s, lfm_pkg::RESP_SLVERR);
      chk(s, 32'h0);
      $display("test host frames done");
      w = 32'h010000 | ($urandom & 32'hFFFF);
      c = crc_m(w);
      bb_frame({w[23:0], c[7:0]}, 32);
      chk(dac2, w[15:0]);
      bb_frame({w[23:0] ^ 24'h00FFFF, c[7:0] ^ 8'h01}, 32);
      chk({flt2[1], l2.alarm, dac2}, {2'h3, w[15:0]});
      bb_frame({12'h000, w[19:0] ^ 20'h0FFFF}, 20);
      chk(dac2, w[15:0]);
      bb_frame({8'h00, w[23:0] ^ 24'h000F0F}, 24);
      chk(dac2, w[15:0] ^ 16'h0F0F);
      $display("test check byte done");
      for (int k = 0; k < 8; k++) begin
         bb_frame({8'h00, 8'h02, 8'h00, 3'h0, k[0], 1'b1, k[2:0]}, 24);
         bb_frame({8'h00, 8'h03, 16'h0000}, 24);
         chk(flt2[1:0], 2'h0);
         repeat (per_ms[k] * MS2 - 10) @(posedge aclk);
         chk(flt2[0], 1'b0);
         repeat (20) @(posedge aclk);
         chk({flt2[0], frc2}, 2'h3);
      end
      $display("test timeout codes done");
      print_verdict();
   end
endmodule : lfm_tb_top
